// ---- pkg/srad_pkg.sv ----
`default_nettype none

package srad_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam logic [5:0] ADDR_EXIT = 6'h00;
   localparam logic [5:0] ADDR_STATUS = 6'h01;
   localparam logic [5:0] ADDR_SERIAL_CFG = 6'h02;
   localparam logic [5:0] ADDR_DIAG_EN = 6'h21;
   localparam logic [5:0] ADDR_DIAG_ERR = 6'h22;
   localparam logic [5:0] ADDR_LIMIT_EN = 6'h25;
   localparam logic [5:0] ADDR_OVER = 6'h26;
   localparam logic [5:0] ADDR_UNDER = 6'h27;

   // Field positions
   localparam int ERR_ROM = 0;
   localparam int ERR_MAP = 1;
   localparam int ERR_IFACE = 2;
   localparam int ERR_WRITE = 3;
   localparam int ERR_READ = 4;
   localparam int CFG_HEADER = 0;

   // Values after reset
   localparam logic [7:0] DIAG_EN_RESET = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;

   // Frame geometry and checksum
   localparam logic [4:0] WORD_SHORT = 5'h10;
   localparam logic [4:0] WORD_LONG = 5'h18;
   localparam logic [7:0] CRC_POLY = 8'h07;

   // Timing
   localparam int CLK_NS = 20;
   localparam int MAP_CHECK_NS = 4000;
   localparam int MAP_CHECK_CYCLES = MAP_CHECK_NS / CLK_NS;
   localparam int SCLK_PERIOD_NS = 320;
   localparam int SCLK_HALF_CYCLES = SCLK_PERIOD_NS / (2 * CLK_NS);

   typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_ADC} srad_op_t;

   // CRC-8, x^8+x^2+x+1, zero seed, first bit first
   function automatic logic [7:0] srad_crc8(input logic [15:0] data);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--)
      begin
         c = {c[6:0], 1'b0} ^ (((c[7] ^ data[i]) == 1'b1) ? CRC_POLY : 8'h00);
      end
      return c;
   endfunction

endpackage

`default_nettype wire

// ---- pkg/srad_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Serial link between controller and converter, all lines one-way
interface srad_if;
   logic sclk;
   logic cs_n;
   logic sdi;
   logic serial_out_first;
   logic [2:0] serial_out_other;

   modport dev (
      input sclk,
      input cs_n,
      input sdi,
      output serial_out_first,
      output serial_out_other
   );

   modport host (
      output sclk,
      output cs_n,
      output sdi,
      input serial_out_first,
      input serial_out_other
   );
endinterface

`default_nettype wire

// ---- rtl/srad_device.sv ----
// Contract
// - header enabled makes each channel 24 bits
// - header: reset, fault, open, over, under, channel
// - read frame starts 0,1, address, eight ignored
// - next frame returns address and register content
// - read in ADC mode keeps data, then registers
// - register mode returns previously addressed register
// - write to address zero returns to ADC
// - write frame 0,0, address, eight data bits
// - controller reads any register before write sequence
// - sample input on fall, shift on rise
// - other three outputs held low always
// - register mode outputs no conversion data
// - CRC enabled gives 24-bit register frames
// - read appends CRC of shifted sixteen bits
// - write CRC checked, mismatch sets error
// - any reset sets reset-seen flag
// - reset-seen cleared only by status read
// - over-limit flags sticky, clear by one/disable
// - under-limit flags sticky, clear by one/disable
// - logic fault is OR of error bits
// - trim CRC checked after reset, default on
// - map CRC rechecked every 4 us when enabled
//
`timescale 1ns/1ps
`default_nettype none

module srad_device (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Serial link
   srad_if.dev link,
   // Conversion results, same clock
   input wire logic [15:0] conv_data [8],
   input wire logic new_sample,
   // Analog monitors, asynchronous
   input wire logic [7:0] over_event,
   input wire logic [7:0] under_event,
   input wire logic open_event,
   input wire logic partial_reset,
   // Trim store, same clock
   input wire logic [15:0] rom_word,
   input wire logic [7:0] rom_crc,
   // Status
   output logic reg_mode_active,
   output logic logic_fault
);

   typedef struct packed {
      logic sclk_s1, sclk_s2, sclk_d;
      logic cs_s1, cs_s2, cs_d;
      logic sdi_s1, sdi_s2;
      logic [7:0] ovr_s1, ovr_s2, und_s1, und_s2;
      logic opn_s1, opn_s2, prst_s1, prst_s2, prst_d;
      logic init_done, reg_mode, map_dirty, reset_seen;
      logic [5:0] prev_addr;
      logic [23:0] rx, tx;
      logic [4:0] rx_cnt, out_cnt;
      logic [2:0] ch;
      logic [7:0] cfg, diag_en, diag_err, lim_en, over, under;
      logic [7:0] map_crc, map_tmr;
   } srad_dev_t;

   srad_dev_t s;
   srad_dev_t next_s;

   logic sclk_fall, sclk_rise, cs_fall, cs_rise, prst_edge;
   logic crc_on, fault, cmd_ok, crc_bad, do_wr, do_rd, wr_ok, map_tick;
   logic [4:0] word_len;
   logic [5:0] cmd_addr;
   logic [7:0] rd_val, status_val, map_now, err_set, w1c_err, w1c_over, w1c_under;
   logic [15:0] rd_word, cmd;
   logic [23:0] word;

   // Addresses that answer a read
   function automatic logic readable(input logic [5:0] a);
      return a == srad_pkg::ADDR_STATUS || a == srad_pkg::ADDR_SERIAL_CFG
         || a == srad_pkg::ADDR_DIAG_EN || a == srad_pkg::ADDR_DIAG_ERR
         || a == srad_pkg::ADDR_LIMIT_EN || a == srad_pkg::ADDR_OVER
         || a == srad_pkg::ADDR_UNDER;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Edges of the synchronised link lines and partial reset
   assign sclk_fall = s.sclk_d & ~s.sclk_s2;
   assign sclk_rise = ~s.sclk_d & s.sclk_s2;
   assign cs_fall = s.cs_d & ~s.cs_s2;
   assign cs_rise = ~s.cs_d & s.cs_s2;
   assign prst_edge = ~s.prst_d & s.prst_s2;

   // Fault summary and status image
   assign fault = |s.diag_err;
   assign status_val = {s.reset_seen, fault, s.opn_s2, |s.over, |s.under, 3'b000};

   // Read mux for the register being returned
   always_comb
   begin
      case (s.prev_addr)
         srad_pkg::ADDR_STATUS: rd_val = status_val;
         srad_pkg::ADDR_SERIAL_CFG: rd_val = s.cfg;
         srad_pkg::ADDR_DIAG_EN: rd_val = s.diag_en;
         srad_pkg::ADDR_DIAG_ERR: rd_val = s.diag_err;
         srad_pkg::ADDR_LIMIT_EN: rd_val = s.lim_en;
         srad_pkg::ADDR_OVER: rd_val = s.over;
         srad_pkg::ADDR_UNDER: rd_val = s.under;
         default: rd_val = 8'h00;
      endcase
   end

   // Word to shift: register image or conversion plus header
   assign crc_on = s.diag_en[srad_pkg::ERR_IFACE];
   assign rd_word = {2'b00, s.prev_addr, rd_val};
   assign word = s.reg_mode ? {rd_word, srad_pkg::srad_crc8(rd_word)}
      : {conv_data[s.ch], s.reset_seen, fault, s.opn_s2,
         s.over[s.ch], s.under[s.ch], s.ch};
   assign word_len = (s.reg_mode ? crc_on : s.cfg[srad_pkg::CFG_HEADER])
      ? srad_pkg::WORD_LONG : srad_pkg::WORD_SHORT;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode at frame end; frames not of the expected 16 or 24 bits are ignored
   assign cmd_ok = cs_rise
      && s.rx_cnt == (crc_on ? srad_pkg::WORD_LONG : srad_pkg::WORD_SHORT);
   assign cmd = crc_on ? s.rx[23:8] : s.rx[15:0];
   assign cmd_addr = cmd[13:8];
   assign crc_bad = crc_on && srad_pkg::srad_crc8(cmd) != s.rx[7:0];
   assign do_wr = cmd_ok & ~crc_bad & ~cmd[15] & ~cmd[14];
   assign do_rd = cmd_ok & ~crc_bad & ~cmd[15] & cmd[14];
   assign wr_ok = cmd_addr == srad_pkg::ADDR_EXIT || (readable(cmd_addr)
      && cmd_addr != srad_pkg::ADDR_STATUS);
   assign w1c_err = (do_wr && cmd_addr == srad_pkg::ADDR_DIAG_ERR) ? cmd[7:0] : 8'h00;
   assign w1c_over = (do_wr && cmd_addr == srad_pkg::ADDR_OVER) ? cmd[7:0] : 8'h00;
   assign w1c_under = (do_wr && cmd_addr == srad_pkg::ADDR_UNDER) ? cmd[7:0] : 8'h00;

   // Memory map checksum over the writable configuration
   assign map_now = srad_pkg::srad_crc8({srad_pkg::srad_crc8({s.cfg, s.diag_en}), s.lim_en});
   assign map_tick = s.map_tmr == 8'(srad_pkg::MAP_CHECK_CYCLES - 1);

   // Error events; the trim check runs once, first cycle after reset
   always_comb
   begin
      err_set = 8'h00;
      err_set[srad_pkg::ERR_ROM] = ~s.init_done & s.diag_en[srad_pkg::ERR_ROM]
         & (srad_pkg::srad_crc8(rom_word) != rom_crc);
      err_set[srad_pkg::ERR_MAP] = map_tick & ~s.map_dirty
         & s.diag_en[srad_pkg::ERR_MAP] & (map_now != s.map_crc);
      err_set[srad_pkg::ERR_IFACE] = cmd_ok & crc_bad & ~cmd[15];
      err_set[srad_pkg::ERR_WRITE] = do_wr & ~wr_ok & s.diag_en[srad_pkg::ERR_WRITE];
      err_set[srad_pkg::ERR_READ] = do_rd & ~readable(cmd_addr)
         & s.diag_en[srad_pkg::ERR_READ];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb
   begin
      next_s = s;
      // Two-stage synchronisers for everything off-domain
      next_s.sclk_s1 = link.sclk;
      next_s.sclk_s2 = s.sclk_s1;
      next_s.sclk_d = s.sclk_s2;
      next_s.cs_s1 = link.cs_n;
      next_s.cs_s2 = s.cs_s1;
      next_s.cs_d = s.cs_s2;
      next_s.sdi_s1 = link.sdi;
      next_s.sdi_s2 = s.sdi_s1;
      next_s.ovr_s1 = over_event;
      next_s.ovr_s2 = s.ovr_s1;
      next_s.und_s1 = under_event;
      next_s.und_s2 = s.und_s1;
      next_s.opn_s1 = open_event;
      next_s.opn_s2 = s.opn_s1;
      next_s.prst_s1 = partial_reset;
      next_s.prst_s2 = s.prst_s1;
      next_s.prst_d = s.prst_s2;
      next_s.init_done = 1'b1;

      // Bit engine; reload on rise only after a fall, so the first edge never
      // re-reads the register (and clears a flag twice)
      if (cs_fall)
      begin
         next_s.rx_cnt = 5'h00;
         next_s.out_cnt = 5'h00;
         next_s.tx = word;
      end
      else if (!s.cs_s2)
      begin
         if (sclk_fall)
         begin
            next_s.rx = {s.rx[22:0], s.sdi_s2};
            if (s.rx_cnt != 5'h1F)
               next_s.rx_cnt = s.rx_cnt + 5'h01;
            if (s.out_cnt == word_len - 5'h01)
            begin
               next_s.out_cnt = 5'h00;
               if (!s.reg_mode)
                  next_s.ch = s.ch + 3'h1;
            end
            else
               next_s.out_cnt = s.out_cnt + 5'h01;
         end
         if (sclk_rise && s.rx_cnt != 5'h00)
            next_s.tx = (s.out_cnt == 5'h00) ? word : {s.tx[22:0], 1'b0};
      end
      if (cs_rise)
         next_s.tx = 24'h000000;
      // Interrupted channel restarts; new sample restarts at the first
      if (new_sample || prst_edge)
         next_s.ch = 3'h0;

      // Mode changes only at frame end, so a read keeps ADC data to the end
      if (do_rd)
      begin
         next_s.reg_mode = 1'b1;
         next_s.prev_addr = cmd_addr;
      end
      if (do_wr)
      begin
         next_s.prev_addr = cmd_addr;
         case (cmd_addr)
            srad_pkg::ADDR_EXIT: next_s.reg_mode = 1'b0;
            srad_pkg::ADDR_SERIAL_CFG: next_s.cfg = cmd[7:0];
            srad_pkg::ADDR_DIAG_EN: next_s.diag_en = cmd[7:0];
            srad_pkg::ADDR_LIMIT_EN: next_s.lim_en = cmd[7:0];
            default: next_s.cfg = s.cfg;
         endcase
      end

      // Sticky flags: a new event wins over a clear in the same cycle
      next_s.reset_seen = (s.reset_seen & ~(cs_fall & s.reg_mode
         & s.prev_addr == srad_pkg::ADDR_STATUS)) | prst_edge;
      next_s.over = ((s.over & ~w1c_over) | (s.ovr_s2 & s.lim_en)) & s.lim_en;
      next_s.under = ((s.under & ~w1c_under) | (s.und_s2 & s.lim_en)) & s.lim_en;
      next_s.diag_err = ((s.diag_err & ~w1c_err) | err_set)
         & {3'b000, s.diag_en[4:0]};

      // Stored map checksum follows every write, checked each period
      next_s.map_dirty = do_wr;
      if (s.map_dirty || !s.diag_en[srad_pkg::ERR_MAP])
         next_s.map_crc = map_now;
      next_s.map_tmr = map_tick ? 8'h00 : s.map_tmr + 8'h01;
   end

   // State register; sclk and cs_n synchronisers reset to idle high
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.cs_s1 <= 1'b1;
         s.cs_s2 <= 1'b1;
         s.cs_d <= 1'b1;
         s.sclk_s1 <= 1'b1;
         s.sclk_s2 <= 1'b1;
         s.sclk_d <= 1'b1;
         s.diag_en <= srad_pkg::DIAG_EN_RESET;
         s.cfg <= srad_pkg::REG_RESET;
         s.reset_seen <= 1'b1;
      end
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign link.serial_out_first = s.tx[23];
   assign link.serial_out_other = 3'b000;
   assign reg_mode_active = s.reg_mode;
   assign logic_fault = fault;

endmodule

`default_nettype wire

// ---- rtl/srad_host.sv ----
`timescale 1ns/1ps
`default_nettype none

module srad_host (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Serial link
   srad_if.host link,
   // Command port
   input wire logic start,
   input wire srad_pkg::srad_op_t op,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic long_frame,
   // Answer
   output logic busy,
   output logic done,
   output logic [23:0] rx_word,
   output logic rx_crc_ok
);

   typedef enum logic [2:0] {IDLE, LEAD, LOW, HIGH, GAP} srad_hst_state_t;

   typedef struct packed {
      srad_hst_state_t st;
      logic [3:0] tmr;
      logic [4:0] bitn, len;
      logic [23:0] tx, rx, rx_word;
      logic sclk, cs_n, sdi, sdo_s1, sdo_s2, busy, done, crc_ok;
   } srad_host_t;

   srad_host_t s;
   srad_host_t next_s;

   logic half_done;
   logic [15:0] cmd;
   logic [23:0] frame;

   ////////////////////////////////////////////////////////////////////////////
   // Frame image; ADC reads keep the data line high so nothing decodes
   always_comb
   begin
      case (op)
         srad_pkg::OP_WRITE: cmd = {2'b00, addr, wdata};
         srad_pkg::OP_READ: cmd = {2'b01, addr, 8'h00};
         default: cmd = 16'hFFFF;
      endcase
   end
   assign frame = {cmd, (long_frame && op != srad_pkg::OP_ADC)
      ? srad_pkg::srad_crc8(cmd) : 8'hFF};
   assign half_done = s.tmr == 4'(srad_pkg::SCLK_HALF_CYCLES - 1);

   // Sequencer: sclk idles high, data driven on rise, captured on fall
   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.sdo_s1 = link.serial_out_first;
      next_s.sdo_s2 = s.sdo_s1;
      next_s.tmr = half_done ? 4'h0 : s.tmr + 4'h1;
      case (s.st)
         IDLE:
         begin
            next_s.tmr = 4'h0;
            if (start)
            begin
               next_s.busy = 1'b1;
               next_s.cs_n = 1'b0;
               next_s.tx = frame;
               next_s.sdi = frame[23];
               next_s.len = long_frame ? srad_pkg::WORD_LONG : srad_pkg::WORD_SHORT;
               next_s.bitn = 5'h00;
               next_s.st = LEAD;
            end
         end
         LEAD, HIGH:
         begin
            if (half_done && s.st == HIGH && s.bitn == s.len)
            begin
               next_s.cs_n = 1'b1;
               next_s.st = GAP;
            end
            else if (half_done)
            begin
               next_s.sclk = 1'b0;
               next_s.rx = {s.rx[22:0], s.sdo_s2};
               next_s.bitn = s.bitn + 5'h01;
               next_s.st = LOW;
            end
         end
         LOW:
         begin
            if (half_done)
            begin
               next_s.sclk = 1'b1;
               next_s.tx = {s.tx[22:0], 1'b1};
               next_s.sdi = s.tx[22];
               next_s.st = HIGH;
            end
         end
         GAP:
         begin
            if (half_done)
            begin
               next_s.done = 1'b1;
               next_s.busy = 1'b0;
               next_s.sdi = 1'b1;
               next_s.rx_word = (s.len == srad_pkg::WORD_LONG) ? s.rx
                  : {8'h00, s.rx[15:0]};
               // Short frames carry no checksum and always pass
               next_s.crc_ok = s.len != srad_pkg::WORD_LONG
                  || srad_pkg::srad_crc8(s.rx[23:8]) == s.rx[7:0];
               next_s.st = IDLE;
            end
         end
         default: next_s.st = IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s <= '0;
         s.st <= IDLE;
         s.sclk <= 1'b1;
         s.cs_n <= 1'b1;
         s.sdi <= 1'b1;
      end
      else
         s <= next_s;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign link.sclk = s.sclk;
   assign link.cs_n = s.cs_n;
   assign link.sdi = s.sdi;
   assign busy = s.busy;
   assign done = s.done;
   assign rx_word = s.rx_word;
   assign rx_crc_ok = s.crc_ok;

endmodule

`default_nettype wire

// ---- dv/srad_properties.sv ----
`timescale 1ns/1ps
`default_nettype none

module srad_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Link lines as seen on the wire
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic serial_out_first,
   input wire logic [2:0] serial_out_other
);

   typedef struct packed {
      logic sclk_q;
      logic cs_q;
      logic [3:0] age;
      logic [4:0] falls;
   } srad_chk_t;

   srad_chk_t st;
   srad_chk_t next_st;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   ////////////////////////////////////////////////////////////////////////////
   // Age since the last link event and count of capture edges in a frame
   always_comb
   begin
      next_st = st;
      next_st.sclk_q = sclk;
      next_st.cs_q = cs_n;
      if ((sclk && !st.sclk_q) || (cs_n != st.cs_q))
      begin
         next_st.age = 4'h0;
      end
      else if (st.age != 4'hF)
      begin
         next_st.age = st.age + 4'h1; // Saturates, only short ages matter
      end
      if (!cs_n && st.cs_q)
      begin
         next_st.falls = 5'h00;
      end
      else if (!cs_n && !sclk && st.sclk_q)
      begin
         next_st.falls = st.falls + 5'h01;
      end
   end

   // Helper state register
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st <= {1'b1, 1'b1, 4'hF, 5'h00};
      end
      else
      begin
         st <= next_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Wire checks
   a_other_lines_low: assert property (serial_out_other == 3'h0)
      else $error("unused outputs not low");
   a_idle_out_low: assert property (cs_n [*8] |-> !serial_out_first)
      else $error("data output active outside a frame");
   a_shift_after_rise: assert property ($changed(serial_out_first) |-> st.age <= 4'h6)
      else $error("data output moved away from a rising clock");
   a_out_steady_fall: assert property ((!cs_n && $fell(sclk))
      |-> $stable(serial_out_first))
      else $error("data output moved at a capture edge");
   a_sdi_held_fall: assert property ((!cs_n && $fell(sclk)) |-> ##1 $stable(sdi) [*4])
      else $error("input data moved right after a capture edge");
   a_sclk_idle_high: assert property ((cs_n && $past(cs_n)) |-> sclk)
      else $error("serial clock not high between frames");
   a_sclk_low_half: assert property ($fell(sclk) |=> !sclk [*7])
      else $error("serial clock low phase too short");
   a_frame_bit_count: assert property ($rose(cs_n)
      |-> (st.falls == 5'h10 || st.falls == 5'h18))
      else $error("frame length not 16 or 24 bits");
   a_select_gap: assert property ($rose(cs_n) |=> cs_n [*7])
      else $error("frame select gap too short");

endmodule

`default_nettype wire

// ---- dv/serial_register_access_diag_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module serial_register_access_diag_tb;

   logic clk;
   logic rstn;
   logic start;
   srad_pkg::srad_op_t op;
   logic [5:0] addr;
   logic [7:0] wdata;
   logic long_frame;
   logic done;
   logic [23:0] rx_word;
   logic busy;
   logic crc_ok;
   logic [15:0] conv_data [8];
   logic new_sample;
   logic [7:0] over_event;
   logic [7:0] under_event;
   logic open_event;
   logic partial_reset;
   logic reg_mode_active;
   logic logic_fault;
   logic [23:0] rx;
   int fail_count;
   int n_compared;

   srad_if link_if ();

   ////////////////////////////////////////////////////////////////////////////
   // Both ends face each other; trim checksum is wrong on purpose
   srad_device srad_device_inst (.clk(clk), .rstn(rstn), .link(link_if),
      .conv_data(conv_data), .new_sample(new_sample), .over_event(over_event),
      .under_event(under_event), .open_event(open_event), .partial_reset(partial_reset),
      .rom_word(16'h0000), .rom_crc(8'h5A), .reg_mode_active(reg_mode_active),
      .logic_fault(logic_fault));

   srad_host srad_host_inst (.clk(clk), .rstn(rstn), .link(link_if), .start(start),
      .op(op), .addr(addr), .wdata(wdata), .long_frame(long_frame), .busy(busy),
      .done(done), .rx_word(rx_word), .rx_crc_ok(crc_ok));

   srad_properties srad_properties_inst (.clk(clk), .rstn(rstn), .sclk(link_if.sclk),
      .cs_n(link_if.cs_n), .sdi(link_if.sdi), .serial_out_first(link_if.serial_out_first),
      .serial_out_other(link_if.serial_out_other));

   // Clock generator
   always #10 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Bitwise checksum, written apart from the design's own helper
   function automatic logic [7:0] crc_of(input logic [15:0] d);
      logic [7:0] c;
      logic fb;
      c = 8'h00;
      for (int i = 15; i >= 0; i--)
      begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0};
         if (fb)
         begin
            c = c ^ 8'h07;
         end
      end
      return c;
   endfunction

   task automatic stop_test();
      if (fail_count == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One whole frame; waits a bounded time for the answer
   task automatic xfer(input srad_pkg::srad_op_t o, input logic [5:0] a, input logic [7:0] d,
                       input logic lng);
      @(posedge clk);
      op <= o;
      addr <= a;
      wdata <= d;
      long_frame <= lng;
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      for (int k = 0; k < 1000 && done !== 1'b1; k++)
         @(posedge clk);
      if (done !== 1'b1)
      begin
         fail_count++;
         $display("mismatch %0t no answer from host", $time);
         stop_test();
      end
      else
         rx = rx_word;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; each register frame answers for the previous address
   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      start = 1'b0;
      op = srad_pkg::OP_ADC;
      addr = 6'h00;
      wdata = 8'h00;
      long_frame = 1'b0;
      new_sample = 1'b0;
      over_event = 8'h00;
      under_event = 8'h00;
      open_event = 1'b0;
      partial_reset = 1'b0;
      fail_count = 0;
      n_compared = 0;
      for (int i = 0; i < 8; i++)
         conv_data[i] = 16'hC300 + 16'(i);
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      idle(4);
      check({23'h000000, logic_fault}, 24'h000001, "trim fault");
      xfer(srad_pkg::OP_ADC, 6'h00, 8'h00, 1'b0);
      check(rx, 24'h00C300, "adc ch0");
      xfer(srad_pkg::OP_ADC, 6'h00, 8'h00, 1'b0);
      check(rx, 24'h00C301, "adc ch1");
      xfer(srad_pkg::OP_READ, srad_pkg::ADDR_STATUS, 8'h00, 1'b0);
      check(rx, 24'h00C302, "read in adc mode");
      check({23'h000000, reg_mode_active}, 24'h000001, "mode");
      xfer(srad_pkg::OP_READ, srad_pkg::ADDR_DIAG_ERR, 8'h00, 1'b0);
      check(rx, 24'h0001C0, "status");
      xfer(srad_pkg::OP_READ, srad_pkg::ADDR_STATUS, 8'h00, 1'b0);
      check(rx, 24'h002201, "errors");
      xfer(srad_pkg::OP_WRITE, srad_pkg::ADDR_DIAG_ERR, 8'h01, 1'b0);
      check(rx, 24'h000140, "status after read");
      xfer(srad_pkg::OP_WRITE, srad_pkg::ADDR_LIMIT_EN, 8'hFF, 1'b0);
      check(rx, 24'h002200, "errors cleared");
      check({23'h000000, logic_fault}, 24'h000000, "fault gone");
      // Short limit events; the flags must outlive them
      over_event <= 8'h08;
      under_event <= 8'h20;
      idle(6);
      over_event <= 8'h00;
      under_event <= 8'h00;
      idle(6);
      xfer(srad_pkg::OP_READ, srad_pkg::ADDR_OVER, 8'h00, 1'b0);
      check(rx, 24'h0025FF, "limit enable");
      xfer(srad_pkg::OP_READ, srad_pkg::ADDR_UNDER, 8'h00, 1'b0);
      check(rx, 24'h002608, "over flags");
      xfer(srad_pkg::OP_WRITE, srad_pkg::ADDR_OVER, 8'h08, 1'b0);
      check(rx, 24'h002720, "under flags");
      xfer(srad_pkg::OP_WRITE, srad_pkg::ADDR_SERIAL_CFG, 8'h01, 1'b0);
      check(rx, 24'h002600, "over flags cleared");
      xfer(srad_pkg::OP_WRITE, srad_pkg::ADDR_DIAG_EN, 8'h07, 1'b0);
      check(rx, 24'h000201, "config");
      idle(450);
      check({23'h000000, logic_fault}, 24'h000000, "map check quiet");
      xfer(srad_pkg::OP_READ, srad_pkg::ADDR_DIAG_ERR, 8'h00, 1'b1);
      check(rx, {16'h2107, crc_of(16'h2107)}, "checked read");
      check({22'h000000, busy, crc_ok}, 24'h000001, "host checksum verdict");
      xfer(srad_pkg::OP_WRITE, srad_pkg::ADDR_EXIT, 8'h00, 1'b1);
      check(rx, {16'h2200, crc_of(16'h2200)}, "checked write");
      check({23'h000000, reg_mode_active}, 24'h000000, "left register mode");
      // Header frames from channel 0 with an open input flagged
      new_sample <= 1'b1;
      open_event <= 1'b1;
      @(posedge clk);
      new_sample <= 1'b0;
      idle(6);
      xfer(srad_pkg::OP_ADC, 6'h00, 8'h00, 1'b1);
      check(rx, 24'hC30020, "header ch0");
      xfer(srad_pkg::OP_ADC, 6'h00, 8'h00, 1'b1);
      check(rx, 24'hC30121, "header ch1");
      partial_reset <= 1'b1;
      idle(4);
      partial_reset <= 1'b0;
      idle(6);
      xfer(srad_pkg::OP_ADC, 6'h00, 8'h00, 1'b1);
      check(rx, 24'hC300A0, "header after partial reset");
      stop_test();
   end

endmodule

`default_nettype wire
